// *** inc/port_pkg.sv ***
// ----------------------------------------------------------------------------
// port register map and pin constants
// ----------------------------------------------------------------------------
package port_pkg;

  localparam int NUM_PORTS = 8;
  localparam int PORT_W    = 8;

  // port order inside the flat pad vectors: a b c d e f g l
  localparam int PORT_L = 7;

  // register indices; byte address is four times the index
  localparam logic [9:0] PORT_A_LATCH_IDX = 10'h002;
  localparam logic [9:0] PORT_B_LATCH_IDX = 10'h005;
  localparam logic [9:0] PORT_G_LATCH_IDX = 10'h014;
  localparam logic [9:0] MCU_CONTROL_IDX  = 10'h035;

  // each port is a group of three: pin input, direction, latch
  localparam logic [9:0] PIN_OFS   = 10'h000;
  localparam logic [9:0] DIR_OFS   = 10'h001;
  localparam logic [9:0] LATCH_OFS = 10'h002;

  localparam logic [9:0] PORT_BASE [NUM_PORTS] = '{
    PORT_A_LATCH_IDX - LATCH_OFS,
    PORT_B_LATCH_IDX - LATCH_OFS,
    10'h006,
    10'h009,
    10'h00c,
    10'h00f,
    PORT_G_LATCH_IDX - LATCH_OFS,
    10'h040
  };

  // implemented bits per port; port g has six pins
  localparam logic [7:0] PORT_MASK [NUM_PORTS] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f, 8'hff
  };

  localparam logic [7:0] PORT_RESET = 8'h00;

  // port l pin roles
  localparam int L_CMP_C_BIT  = 5;
  localparam int L_CMP_B_BIT  = 4;
  localparam int L_CMP_A_BIT  = 3;
  localparam int L_T5_CLK_BIT = 2;
  localparam int L_TIMER5_CAPTURE_TRIGGER_BIT   = 1;
  localparam int L_TIMER4_CAPTURE_TRIGGER_BIT   = 0;

  // mcu control fields
  localparam int DEBUG_DIS_BIT = 7;
  localparam int PUD_BIT       = 4;
  localparam int VEC_SEL_BIT   = 1;
  localparam int VEC_CHG_BIT   = 0;
  localparam logic [7:0] MCU_RW_MASK = 8'h93;
  localparam logic [7:0] MCU_RESET   = 8'h00;

endpackage

// *** logic/port_pin_override_regs.sv ***
// How it works
// - pin l5 carries compare c when enabled and set as output
// - pin l4 carries compare b when enabled and set as output
// - pin l3 carries compare a when enabled and set as output
// - pwm waveform uses the same override path
// - pin l2 input feeds timer5 count source
// - pin l1 input feeds timer5 capture
// - pin l0 input feeds timer4 capture
// - global pull-up disable kills every pull-up
// - pull-up on when input and latch one
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps

module port_pin_override_regs (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [63:0] pad_in,
  output logic      [63:0] pad_out,
  output logic      [63:0] pad_oe_n,
  output logic      [63:0] pad_pullup,
  input  wire logic        timer5_compare_out_a,
  input  wire logic        timer5_compare_out_b,
  input  wire logic        timer5_compare_out_c,
  input  wire logic        timer5_compare_en_a,
  input  wire logic        timer5_compare_en_b,
  input  wire logic        timer5_compare_en_c,
  output logic             timer5_ext_count_in,
  output logic             timer5_capture_trigger,
  output logic             timer4_capture_trigger,
  output logic             debug_port_disable,
  output logic             vector_table_select,
  output logic             vector_change_enable
);

  localparam int NP = port_pkg::NUM_PORTS;
  localparam int W  = port_pkg::PORT_W;
  localparam int LB = port_pkg::PORT_L * W;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic [NP*W-1:0] latch_all;
  logic [NP*W-1:0] dir_all;
  logic [NP*W-1:0] pin_sample;
  logic [7:0]      mcu_control;

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  wire [9:0] reg_idx = paddr[11:2];
  wire       aligned = (paddr[1:0] == 2'b00);
  wire       setup   = psel & ~penable;
  wire       mcu_hit = aligned & (reg_idx == port_pkg::MCU_CONTROL_IDX);
  wire       global_pullup_disable     = mcu_control[port_pkg::PUD_BIT];

  logic [NP-1:0] hit_pin;
  logic [NP-1:0] hit_dir;
  logic [NP-1:0] hit_lat;
  logic [W-1:0]  rd_part [NP];

  genvar k;
  generate
    for (k = 0; k < NP; k++) begin : g_dec
      assign hit_pin[k] = aligned & (reg_idx == port_pkg::PORT_BASE[k] + port_pkg::PIN_OFS);
      assign hit_dir[k] = aligned & (reg_idx == port_pkg::PORT_BASE[k] + port_pkg::DIR_OFS);
      assign hit_lat[k] = aligned & (reg_idx == port_pkg::PORT_BASE[k] + port_pkg::LATCH_OFS);
      assign rd_part[k] = port_pkg::PORT_MASK[k] &
                          (({W{hit_pin[k]}} & pin_sample[k*W +: W]) |
                           ({W{hit_dir[k]}} & dir_all[k*W +: W]) |
                           ({W{hit_lat[k]}} & latch_all[k*W +: W]));
    end
  endgenerate

  wire any_hit = mcu_hit | (|hit_pin) | (|hit_dir) | (|hit_lat);
  // unmapped or misaligned writes are dropped and flagged with pslverr
  wire wr_fire = ce & psel & penable & pready & pwrite & any_hit;

  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = {8{mcu_hit}} & mcu_control;
    for (int i = 0; i < NP; i++) begin
      rd_byte = rd_byte | rd_part[i];
    end
  end

  // --------------------------------------------------------------------------
  // apb answer: one wait-free access, data captured in the setup cycle
  // --------------------------------------------------------------------------
  // answer on the first enabled edge that sees psel with no answer standing,
  // so a setup edge swallowed by a low ce does not hang the master
  wire take = psel & ~pready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= take;
      pslverr <= take & ~any_hit;
      if (take) begin
        prdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // --------------------------------------------------------------------------
  // software registers
  // --------------------------------------------------------------------------
  // a write of ones to the pin input register flips the latch bits,
  // so software can toggle a pin without a read-modify-write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_all   <= {NP{port_pkg::PORT_RESET}};
      dir_all     <= {NP{port_pkg::PORT_RESET}};
      mcu_control <= port_pkg::MCU_RESET;
      pin_sample  <= '0;
    end else if (ce) begin
      pin_sample <= pad_in;
      if (wr_fire && mcu_hit) begin
        mcu_control <= pwdata[7:0] & port_pkg::MCU_RW_MASK;
      end
      for (int i = 0; i < NP; i++) begin
        if (wr_fire && hit_lat[i]) begin
          latch_all[i*W +: W] <= pwdata[7:0] & port_pkg::PORT_MASK[i];
        end else if (wr_fire && hit_pin[i]) begin
          latch_all[i*W +: W] <= latch_all[i*W +: W] ^ (pwdata[7:0] & port_pkg::PORT_MASK[i]);
        end
        if (wr_fire && hit_dir[i]) begin
          dir_all[i*W +: W] <= pwdata[7:0] & port_pkg::PORT_MASK[i];
        end
      end
    end
  end

  assign debug_port_disable   = mcu_control[port_pkg::DEBUG_DIS_BIT];
  assign vector_table_select  = mcu_control[port_pkg::VEC_SEL_BIT];
  assign vector_change_enable = mcu_control[port_pkg::VEC_CHG_BIT];

  // --------------------------------------------------------------------------
  // pin override for port l
  // --------------------------------------------------------------------------
  // compare and pwm share one path: the timer owns the waveform
  wire [W-1:0] l_ovr_en  = {2'b00, timer5_compare_en_c, timer5_compare_en_b,
                            timer5_compare_en_a, 3'b000};
  wire [W-1:0] l_ovr_val = {2'b00, timer5_compare_out_c, timer5_compare_out_b,
                            timer5_compare_out_a, 3'b000};
  wire [W-1:0] l_latch   = latch_all[LB +: W];

  wire [NP*W-1:0] next_pad_out = {(l_latch & ~l_ovr_en) | (l_ovr_val & l_ovr_en),
                                  latch_all[LB-1:0]};
  // direction is never overridden; a compare pin set as input stays quiet
  wire [NP*W-1:0] next_pad_oe_n = ~dir_all;
  wire [NP*W-1:0] next_pad_pullup = ~dir_all & latch_all & {(NP*W){~global_pullup_disable}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out    <= '0;
      pad_oe_n   <= '1;
      pad_pullup <= '0;
    end else if (ce) begin
      pad_out    <= next_pad_out;
      pad_oe_n   <= next_pad_oe_n;
      pad_pullup <= next_pad_pullup;
    end
  end

  // --------------------------------------------------------------------------
  // timer input taps, taken from the sampled pins
  // --------------------------------------------------------------------------
  assign timer5_ext_count_in    = pin_sample[LB + port_pkg::L_T5_CLK_BIT];
  assign timer5_capture_trigger = pin_sample[LB + port_pkg::L_TIMER5_CAPTURE_TRIGGER_BIT];
  assign timer4_capture_trigger = pin_sample[LB + port_pkg::L_TIMER4_CAPTURE_TRIGGER_BIT];

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_write(logic [9:0] idx);
    psel && penable && pready && pwrite && ce && aligned && reg_idx == idx;
  endsequence

  sequence s_pud_set;
    s_apb_write(port_pkg::MCU_CONTROL_IDX) && pwdata[port_pkg::PUD_BIT];
  endsequence

  sequence s_cmp_a_held;
    (ce && timer5_compare_en_a) [*2];
  endsequence

  sequence s_cmp_b_held;
    (ce && timer5_compare_en_b) [*2];
  endsequence

  sequence s_cmp_c_held;
    (ce && timer5_compare_en_c) [*2];
  endsequence

  sequence s_apb_setup;
    ce && setup && !pready;
  endsequence

  sequence s_bad_write;
    psel && penable && pready && pwrite && ce && !any_hit;
  endsequence

  a_oc_c_drive: assert property (
    ce && dir_all[LB+5] && timer5_compare_en_c
    |=> pad_out[LB+5] == $past(timer5_compare_out_c) && !pad_oe_n[LB+5])
    else $error("pin l5 does not carry compare c");

  a_oc_b_drive: assert property (
    ce && dir_all[LB+4] && timer5_compare_en_b
    |=> pad_out[LB+4] == $past(timer5_compare_out_b) && !pad_oe_n[LB+4])
    else $error("pin l4 does not carry compare b");

  a_oc_a_drive: assert property (
    ce && dir_all[LB+3] && timer5_compare_en_a
    |=> pad_out[LB+3] == $past(timer5_compare_out_a) && !pad_oe_n[LB+3])
    else $error("pin l3 does not carry compare a");

  a_oc_c_quiet: assert property (
    ce && !dir_all[LB+5] |=> pad_oe_n[LB+5])
    else $error("pin l5 driven while set as input");

  a_oc_b_quiet: assert property (
    ce && !dir_all[LB+4] |=> pad_oe_n[LB+4])
    else $error("pin l4 driven while set as input");

  a_oc_a_quiet: assert property (
    ce && !dir_all[LB+3] |=> pad_oe_n[LB+3])
    else $error("pin l3 driven while set as input");

  a_oc_c_idle: assert property (
    ce && !timer5_compare_en_c |=> pad_out[LB+5] == $past(latch_all[LB+5]))
    else $error("pin l5 lost its latch value");

  a_oc_b_idle: assert property (
    ce && !timer5_compare_en_b |=> pad_out[LB+4] == $past(latch_all[LB+4]))
    else $error("pin l4 lost its latch value");

  a_oc_a_idle: assert property (
    ce && !timer5_compare_en_a |=> pad_out[LB+3] == $past(latch_all[LB+3]))
    else $error("pin l3 lost its latch value");

  a_pwm_follow_path: assert property (
    s_cmp_a_held
    |=> pad_out[LB+3] == $past(timer5_compare_out_a)
        && $past(pad_out[LB+3]) == $past(timer5_compare_out_a, 2))
    else $error("pwm waveform lost on pin l3");

  a_pwm_path_b: assert property (
    s_cmp_b_held
    |=> pad_out[LB+4] == $past(timer5_compare_out_b)
        && $past(pad_out[LB+4]) == $past(timer5_compare_out_b, 2))
    else $error("pwm waveform lost on pin l4");

  a_pwm_path_c: assert property (
    s_cmp_c_held
    |=> pad_out[LB+5] == $past(timer5_compare_out_c)
        && $past(pad_out[LB+5]) == $past(timer5_compare_out_c, 2))
    else $error("pwm waveform lost on pin l5");

  a_t5_count_tap: assert property (
    ce |=> timer5_ext_count_in == $past(pad_in[LB+2]))
    else $error("timer5 count source not from pin l2");

  a_timer5_capture_trigger_tap: assert property (
    ce |=> timer5_capture_trigger == $past(pad_in[LB+1]))
    else $error("timer5 capture not from pin l1");

  a_timer4_capture_trigger_tap: assert property (
    ce |=> timer4_capture_trigger == $past(pad_in[LB]))
    else $error("timer4 capture not from pin l0");

  a_pud_kills_all: assert property (
    s_pud_set ##1 ce |=> pad_pullup == '0)
    else $error("pull-up active while globally disabled");

  a_pud_all_ports: assert property (
    ce && global_pullup_disable |=> pad_pullup == '0)
    else $error("pull-up left on with global disable set");

  a_pullup_all: assert property (
    ce |=> pad_pullup == ($past(~dir_all & latch_all) & {(NP*W){!$past(global_pullup_disable)}}))
    else $error("pull-up does not follow direction and latch");

  a_pullup_enable: assert property (
    ce && !global_pullup_disable && !dir_all[LB+7] && latch_all[LB+7] |=> pad_pullup[LB+7])
    else $error("pull-up missing on input pin with latch one");

  a_no_dir_override: assert property (
    ce |=> pad_oe_n[LB+5:LB+3] == ~$past(dir_all[LB+5:LB+3])
           && pad_pullup[LB+5:LB+3] == ($past(~dir_all[LB+5:LB+3]
              & latch_all[LB+5:LB+3]) & {3{!$past(global_pullup_disable)}}))
    else $error("alternate function touched direction or pull-up");

  a_l_keep_pullup: assert property (
    ce && !dir_all[LB+5] && latch_all[LB+5] && !global_pullup_disable && timer5_compare_en_c
    |=> pad_pullup[LB+5])
    else $error("compare enable removed the pull-up on pin l5");

  a_plain_gpio: assert property (
    ce |=> pad_out[LB+7:LB+6] == $past(latch_all[LB+7:LB+6]))
    else $error("pins l7 l6 not plain gpio");

  a_gpio_dir: assert property (
    ce |=> pad_oe_n[LB+7:LB+6] == ~$past(dir_all[LB+7:LB+6]))
    else $error("pins l7 l6 drive does not follow direction");

  a_latch_write_l: assert property (
    s_apb_write(port_pkg::PORT_BASE[port_pkg::PORT_L] + port_pkg::LATCH_OFS)
    |=> latch_all[LB +: W] == $past(pwdata[7:0]))
    else $error("port l latch write lost");

  a_pin_write_toggle: assert property (
    s_apb_write(port_pkg::PORT_BASE[port_pkg::PORT_L] + port_pkg::PIN_OFS)
    |=> latch_all[LB +: W] == $past(latch_all[LB +: W] ^ pwdata[7:0]))
    else $error("port l pin write did not toggle the latch");

  a_dir_write_l: assert property (
    s_apb_write(port_pkg::PORT_BASE[port_pkg::PORT_L] + port_pkg::DIR_OFS)
    |=> dir_all[LB +: W] == $past(pwdata[7:0]))
    else $error("port l direction write lost");

  a_other_ports_out: assert property (
    ce |=> pad_out[LB-1:0] == $past(latch_all[LB-1:0]))
    else $error("ports a to g do not drive their latch");

  // --------------------------------------------------------------------------
  // bus and clock enable
  // --------------------------------------------------------------------------
  a_ce_freeze: assert property (
    !ce |=> $stable(pad_out) && $stable(pad_oe_n) && $stable(pad_pullup)
            && $stable(pin_sample) && $stable(pready))
    else $error("state moved while clock enable low");

  a_apb_ready_next: assert property (
    s_apb_setup |=> pready)
    else $error("apb answer not one cycle after setup");

  a_apb_ready_drop: assert property (
    ce && pready |=> !pready)
    else $error("apb answer stood longer than one cycle");

  a_apb_err_pair: assert property (
    pslverr |-> pready)
    else $error("pslverr without pready");

  a_bad_write_dropped: assert property (
    s_bad_write
    |=> $stable(latch_all) && $stable(dir_all) && $stable(mcu_control))
    else $error("refused write changed a register");

endmodule

// *** test/pin_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// pins outside the device
// ----------------------------------------------------------------------------
module pin_model (
  input  wire logic [63:0] pad_out,
  input  wire logic [63:0] pad_oe_n,
  input  wire logic [63:0] pad_pullup,
  input  wire logic [63:0] ext_level,
  output logic      [63:0] pad_in
);
  // a driven pin follows the device; a released pin with pull-up reads high,
  // otherwise whatever the board applies, so a stale drive value never shows
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & (pad_pullup | ext_level));
endmodule

// *** test/port_pin_override_regs_tb_top.sv ***
`timescale 1ns/1ps

module port_pin_override_regs_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ce;
  logic [7:0]  snap;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed_val;
  logic [63:0] pad_in, pad_out, pad_oe_n, pad_pullup, ext_level;
  logic [2:0]  en3, cmp3, taps, mcu_out;
  logic [7:0]  dir_m [8];
  logic [7:0]  lat_m [8];
  logic [7:0]  mcu_m, v;
  int          fail_count, samples_checked, k;

  port_pin_override_regs dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
    .timer5_compare_out_a(cmp3[0]), .timer5_compare_out_b(cmp3[1]),
    .timer5_compare_out_c(cmp3[2]), .timer5_compare_en_a(en3[0]),
    .timer5_compare_en_b(en3[1]), .timer5_compare_en_c(en3[2]),
    .timer5_ext_count_in(taps[2]), .timer5_capture_trigger(taps[1]),
    .timer4_capture_trigger(taps[0]), .debug_port_disable(mcu_out[2]),
    .vector_table_select(mcu_out[1]), .vector_change_enable(mcu_out[0]));

  pin_model pins_u (.pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
    .ext_level(ext_level), .pad_in(pad_in));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // --------------------------------------------------------------------------
  // reference model
  // --------------------------------------------------------------------------
  function automatic logic [11:0] adr(int p, logic [9:0] ofs);
    return {port_pkg::PORT_BASE[p] + ofs, 2'b00};
  endfunction

  function automatic logic [7:0] out_exp(int p);
    logic [7:0] o;
    o = lat_m[p];
    if (p == port_pkg::PORT_L) begin
      for (int b = 0; b < 3; b++) if (en3[b]) o[port_pkg::L_CMP_A_BIT + b] = cmp3[b];
    end
    return o;
  endfunction

  function automatic logic [7:0] pu_exp(int p);
    return ~dir_m[p] & lat_m[p] & {8{~mcu_m[port_pkg::PUD_BIT]}};
  endfunction

  function automatic logic [7:0] pin_exp(int p);
    return ((dir_m[p] & out_exp(p)) | (~dir_m[p] & (pu_exp(p) | ext_level[8*p +: 8])))
           & port_pkg::PORT_MASK[p];
  endfunction

  // --------------------------------------------------------------------------
  // bus and compare tasks
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    forever begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      n++;
      if (n > 40) begin
        check("pready", 32'h0000_0000, 32'h0000_0001);
        break;
      end
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp,
                        input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(name, r, exp);
    check("pslverr", {31'h0, e}, {31'h0, exp_err});
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'($urandom), d}, r, e);
  endtask

  task automatic check_port(int p);
    check("pad_out", {24'h00_0000, pad_out[8*p +: 8] & dir_m[p]}, out_exp(p) & dir_m[p]);
    check("pad_oe_n", {24'h00_0000, pad_oe_n[8*p +: 8]}, {24'h00_0000, ~dir_m[p]});
    check("pad_pullup", {24'h00_0000, pad_pullup[8*p +: 8]}, pu_exp(p));
    v = pin_exp(port_pkg::PORT_L);
    check("taps", {29'h0, taps}, {29'h0, v[2:0]});
    rd_chk("pin", adr(p, port_pkg::PIN_OFS), {24'h00_0000, pin_exp(p)}, 1'b0);
    rd_chk("dir", adr(p, port_pkg::DIR_OFS), {24'h00_0000, dir_m[p]}, 1'b0);
    rd_chk("latch", adr(p, port_pkg::LATCH_OFS), {24'h00_0000, lat_m[p]}, 1'b0);
    rd_chk("mcu", {port_pkg::MCU_CONTROL_IDX, 2'b00}, {24'h00_0000, mcu_m}, 1'b0);
    check("mcu_out", {29'h0, mcu_out}, {29'h0, mcu_m[7], mcu_m[1:0]});
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {en3, cmp3, mcu_m} = '0;
    ext_level = 64'h0000_0000_0000_0000;
    fail_count = 0;
    samples_checked = 0;
    for (int p = 0; p < 8; p++) {dir_m[p], lat_m[p]} = 16'h0000;
    seed_val = $urandom(32'h0000_7e4b);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int p = 0; p < 8; p++) check_port(p);
    $display("test reset values done");
    for (int i = 0; i < 48; i++) begin
      k = (i % 2 == 1) ? port_pkg::PORT_L : $urandom_range(0, 7);
      v = 8'($urandom);
      dir_m[k] = v & port_pkg::PORT_MASK[k];
      wr(adr(k, port_pkg::DIR_OFS), v);
      v = 8'($urandom);
      lat_m[k] = v & port_pkg::PORT_MASK[k];
      wr(adr(k, port_pkg::LATCH_OFS), v);
      v = 8'($urandom);
      mcu_m = v & port_pkg::MCU_RW_MASK;
      wr({port_pkg::MCU_CONTROL_IDX, 2'b00}, v);
      ext_level <= {$urandom, $urandom};
      en3 <= 3'($urandom);
      cmp3 <= 3'($urandom);
      repeat (3) @(posedge pclk);
      check_port(k);
      // clock enable low: compare and pin changes must not reach the outputs
      snap = out_exp(port_pkg::PORT_L) & dir_m[port_pkg::PORT_L];
      ce <= 1'b0;
      cmp3 <= ~cmp3;
      ext_level <= ~ext_level;
      repeat (3) @(posedge pclk);
      check("frozen pad_out", {24'h00_0000, pad_out[63:56] & dir_m[7]}, {24'h00_0000, snap});
      check("frozen taps", {29'h0, taps}, {29'h0, v[2:0]});
      ce <= 1'b1;
    end
    $display("test random pins done");
    v = 8'($urandom);
    lat_m[port_pkg::PORT_L] ^= v;
    wr(adr(port_pkg::PORT_L, port_pkg::PIN_OFS), v);
    rd_chk("toggle", adr(port_pkg::PORT_L, port_pkg::LATCH_OFS),
           {24'h00_0000, lat_m[port_pkg::PORT_L]}, 1'b0);
    $display("test pin toggle done");
    // a refused write must leave the latch alone
    wr(adr(0, port_pkg::LATCH_OFS) | 12'h002, 8'h5a);
    rd_chk("unmapped", 12'h3fc, 32'h0000_0000, 1'b1);
    rd_chk("misaligned", adr(0, port_pkg::LATCH_OFS) | 12'h001, 32'h0000_0000, 1'b1);
    rd_chk("latch kept", adr(0, port_pkg::LATCH_OFS), {24'h00_0000, lat_m[0]}, 1'b0);
    $display("test refused access done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
endmodule
